// [pkg/nvac_pkg.sv]
// constants of the nonvolatile byte access controller
// assumes a cpu io port with 6-bit io addresses and one core clock
// What this block does
// - byte-wide separate nonvolatile space, 512 or 1024 bytes
// - read stalls cpu four cycles
// - write start stalls cpu two cycles, four when read strobe set in the same write
// - write strobe shows self-timed write completion
// - system reset lets running write finish
// - 12-bit linear address, bits 15:12 read zero
// - address undefined after reset, software loads it
// - data register feeds writes, receives read bytes
// - mode: atomic, erase only, write only, reserved
// - mode writes ignored while write strobe set
// - reset clears mode unless programming busy
// - ready interrupt needs enable and global enable
// - ready interrupt is level while strobe zero
// - strobe within four cycles of master enable
// - no master enable means strobe does nothing
// - master enable self-clears after four cycles
// - write strobe self-clears when programming ends
// - read strobe fetches byte within the instruction
// - busy write blocks reads and address changes
// - timing counted on rc oscillator, 26368 cycles atomic, 13959 for erase only or write only
package nvac_pkg;
    localparam logic [5:0] CTRL_ADDR     = 6'h1F;
    localparam logic [5:0] DATA_ADDR     = 6'h20;
    localparam logic [5:0] ADDR_LO_ADDR  = 6'h21;
    localparam logic [5:0] ADDR_HI_ADDR  = 6'h22;
    localparam int         READ_BIT      = 0;
    localparam int         WSTROBE_BIT   = 1;
    localparam int         MWE_BIT       = 2;
    localparam int         RIE_BIT       = 3;
    localparam int         MODE_LSB      = 4;
    localparam int         ADDR_BITS     = 12;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;
    localparam logic [2:0] READ_STALL    = 3'h4;
    localparam logic [2:0] WRITE_STALL   = 3'h2;
    localparam logic [2:0] MWE_WINDOW    = 3'h4;
    localparam int         CLK_HZ        = 25_000_000;
    localparam int         ATOMIC_US     = 3400;
    localparam int         SPLIT_US      = 1800;
    localparam int         ATOMIC_RC     = 26368;
    localparam int         SPLIT_RC      = ATOMIC_RC * SPLIT_US / ATOMIC_US;
    typedef enum logic [1:0]
    {
        MODE_ATOMIC   = 2'b00,
        MODE_ERASE    = 2'b01,
        MODE_WRITE    = 2'b10,
        MODE_RESERVED = 2'b11
    } nvac_mode_type;
    typedef enum logic [1:0]
    {
        ENG_IDLE   = 2'b00,
        ENG_RUN    = 2'b01,
        ENG_COMMIT = 2'b10
    } nvac_eng_type;
endpackage

// [rtl/nvac_mem.sv]
// byte array of the nonvolatile space, registered read data
// assumes one port: writes only from the programming engine
`timescale 1ns/100ps
module nvac_mem #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic          i_core_clk,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_we,
    input  wire logic          i_and_mode,
    input  wire logic [7:0]    i_wdata,
    output logic      [7:0]    o_rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] cells;
        logic [7:0]            rdata;
    } nvac_mem_state_type;

    nvac_mem_state_type st;
    nvac_mem_state_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.rdata = st.cells[i_addr];
        if (i_we)
        begin
            // write only can clear bits, never set them
            next_st.cells[i_addr] = i_and_mode ? (st.cells[i_addr] & i_wdata) : i_wdata;
        end
    end

    // contents are nonvolatile: no reset
    always_ff @(posedge i_core_clk)
    begin
        st <= next_st;
    end

    assign o_rdata = st.rdata;
endmodule

// [rtl/nvac_engine.sv]
// self-timed programming engine, kept alive across system reset
// assumes i_por_n is power-on reset only; rc oscillator is asynchronous
`timescale 1ns/100ps
module nvac_engine #(
    parameter int ATOMIC_CYC = 26368,
    parameter int SPLIT_CYC  = 13959,
    parameter int AW         = 10
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_por_n,
    input  wire logic          i_rst_n,
    input  wire logic          i_rc_osc,
    input  wire logic          i_start,
    input  wire logic          i_mode_we,
    input  wire logic [1:0]    i_mode_wdata,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_data,
    output logic               o_busy,
    output logic      [1:0]    o_mode,
    output logic               o_arr_we,
    output logic               o_arr_and,
    output logic      [AW-1:0] o_arr_addr,
    output logic      [7:0]    o_arr_wdata
);
    typedef struct packed {
        nvac_pkg::nvac_eng_type state;
        logic [1:0]             mode;
        logic [2:0]             rc_sync;
        logic [1:0]             rst_sync;
        logic [14:0]            cnt;
        logic                   busy;
        logic                   arr_we;
        logic                   arr_and;
        logic [AW-1:0]          addr;
        logic [7:0]             wdata;
    } nvac_eng_state_type;

    nvac_eng_state_type st;
    nvac_eng_state_type next_st;
    logic [1:0]         eff_mode;

    always_comb
    begin
        next_st = st;
        eff_mode = (i_mode_we && !st.busy) ? i_mode_wdata : st.mode;
        next_st.rc_sync = {st.rc_sync[1:0], i_rc_osc};
        next_st.rst_sync = {st.rst_sync[0], i_rst_n};
        next_st.arr_we = 1'b0;
        if (!st.busy)
        begin
            next_st.mode = eff_mode;
        end
        case (st.state)
            nvac_pkg::ENG_IDLE:
            begin
                if (i_start && eff_mode != nvac_pkg::MODE_RESERVED)
                begin
                    next_st.state = nvac_pkg::ENG_RUN;
                    next_st.busy = 1'b1;
                    next_st.addr = i_addr;
                    next_st.arr_and = (eff_mode == nvac_pkg::MODE_WRITE);
                    next_st.wdata = (eff_mode == nvac_pkg::MODE_ERASE) ? nvac_pkg::ERASED_BYTE : i_data;
                    next_st.cnt = (eff_mode == nvac_pkg::MODE_ATOMIC) ? 15'(ATOMIC_CYC) : 15'(SPLIT_CYC);
                end
            end
            nvac_pkg::ENG_RUN:
            begin
                if (st.rc_sync[1] && !st.rc_sync[2])
                begin
                    next_st.cnt = st.cnt - 15'h0001;
                    if (st.cnt == 15'h0001)
                    begin
                        // array write lands while busy still blocks reads
                        next_st.arr_we = 1'b1;
                        next_st.state = nvac_pkg::ENG_COMMIT;
                    end
                end
            end
            nvac_pkg::ENG_COMMIT:
            begin
                next_st.busy = 1'b0;
                next_st.state = nvac_pkg::ENG_IDLE;
            end
            default:
            begin
                next_st.state = nvac_pkg::ENG_IDLE;
            end
        endcase
        if (!st.rst_sync[1] && !st.busy)
        begin
            next_st.mode = nvac_pkg::MODE_ATOMIC;
        end
    end

    // only power-on resets the engine, so a system reset never aborts it
    always_ff @(posedge i_core_clk or negedge i_por_n)
    begin
        if (!i_por_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_busy = st.busy;
    assign o_mode = st.mode;
    assign o_arr_we = st.arr_we;
    assign o_arr_and = st.arr_and;
    assign o_arr_addr = st.addr;
    assign o_arr_wdata = st.wdata;
endmodule

// [rtl/nvac_top.sv]
// cpu-facing register set of the nonvolatile byte access controller
// assumes a single-cycle io port from the cpu core on i_core_clk
`timescale 1ns/100ps
module nvac_top #(
    parameter int DEPTH      = 1024,
    parameter int AW         = 10,
    parameter int ATOMIC_CYC = nvac_pkg::ATOMIC_RC,
    parameter int SPLIT_CYC  = nvac_pkg::SPLIT_RC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_por_n,
    input  wire logic       i_rc_osc,
    input  wire logic [5:0] i_io_addr,
    input  wire logic       i_io_we,
    input  wire logic       i_io_re,
    input  wire logic [7:0] i_io_wdata,
    input  wire logic       i_global_irq_en,
    output logic      [7:0] o_io_rdata,
    output logic            o_cpu_stall,
    output logic            o_ready_irq
);
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        rie;
        logic        mwe;
        logic [2:0]  mwe_cnt;
        logic [2:0]  stall_cnt;
        logic        stall;
        logic        rd_pend;
        logic [7:0]  rdata;
        logic        irq;
    } nvac_top_state_type;

    nvac_top_state_type st;
    nvac_top_state_type next_st;

    logic          busy;
    logic [1:0]    mode;
    logic          arr_we;
    logic          arr_and;
    logic [AW-1:0] arr_addr;
    logic [7:0]    arr_wdata;
    logic [7:0]    mem_rdata;
    logic [AW-1:0] mem_addr;
    logic          ctrl_we;
    logic          rd_trig;
    logic          wr_start;

    function automatic logic [7:0] read_mux(input logic [5:0] a,
                                            input nvac_top_state_type s,
                                            input logic [1:0] m,
                                            input logic b);
        logic [7:0] r;
        r = 8'h00;
        if (a == nvac_pkg::CTRL_ADDR)
        begin
            r[nvac_pkg::MODE_LSB +: 2] = m;
            r[nvac_pkg::RIE_BIT] = s.rie;
            r[nvac_pkg::MWE_BIT] = s.mwe;
            r[nvac_pkg::WSTROBE_BIT] = b;
        end
        else if (a == nvac_pkg::DATA_ADDR)
        begin
            r = s.data;
        end
        else if (a == nvac_pkg::ADDR_LO_ADDR)
        begin
            r = s.addr[7:0];
        end
        else if (a == nvac_pkg::ADDR_HI_ADDR)
        begin
            r = {4'h0, s.addr[11:8]};
        end
        return r;
    endfunction

    assign ctrl_we = i_io_we && (i_io_addr == nvac_pkg::CTRL_ADDR);
    assign rd_trig = ctrl_we && i_io_wdata[nvac_pkg::READ_BIT] && !busy;
    assign wr_start = ctrl_we && i_io_wdata[nvac_pkg::WSTROBE_BIT] && st.mwe && !busy;
    assign mem_addr = arr_we ? arr_addr : st.addr[AW-1:0];

    always_comb
    begin
        next_st = st;
        next_st.rd_pend = rd_trig;
        if (st.rd_pend)
        begin
            next_st.data = mem_rdata;
        end
        if (i_io_we && i_io_addr == nvac_pkg::DATA_ADDR)
        begin
            next_st.data = i_io_wdata;
        end
        if (i_io_we && !busy && i_io_addr == nvac_pkg::ADDR_LO_ADDR)
        begin
            next_st.addr[7:0] = i_io_wdata;
        end
        if (i_io_we && !busy && i_io_addr == nvac_pkg::ADDR_HI_ADDR)
        begin
            next_st.addr[11:8] = i_io_wdata[3:0];
        end
        // master enable window
        if (st.mwe)
        begin
            next_st.mwe_cnt = st.mwe_cnt - 3'h1;
            if (st.mwe_cnt == 3'h1)
            begin
                next_st.mwe = 1'b0;
            end
        end
        if (ctrl_we)
        begin
            next_st.rie = i_io_wdata[nvac_pkg::RIE_BIT];
            if (i_io_wdata[nvac_pkg::MWE_BIT] && !wr_start)
            begin
                next_st.mwe = 1'b1;
                next_st.mwe_cnt = nvac_pkg::MWE_WINDOW;
            end
        end
        if (wr_start)
        begin
            next_st.mwe = 1'b0;
        end
        // cpu stall counter
        if (st.stall_cnt != 3'h0)
        begin
            next_st.stall_cnt = st.stall_cnt - 3'h1;
        end
        if (rd_trig)
        begin
            next_st.stall_cnt = nvac_pkg::READ_STALL;
        end
        else if (wr_start)
        begin
            next_st.stall_cnt = nvac_pkg::WRITE_STALL;
        end
        next_st.stall = (next_st.stall_cnt != 3'h0);
        next_st.rdata = i_io_re ? read_mux(i_io_addr, st, mode, busy) : st.rdata;
        next_st.irq = next_st.rie && i_global_irq_en && !busy;
    end

    // address resets to zero here but is architecturally undefined
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    nvac_engine #(
        .ATOMIC_CYC (ATOMIC_CYC),
        .SPLIT_CYC  (SPLIT_CYC),
        .AW         (AW)
    ) u_engine (
        .i_core_clk   (i_core_clk),
        .i_por_n      (i_por_n),
        .i_rst_n      (i_rst_n),
        .i_rc_osc     (i_rc_osc),
        .i_start      (wr_start),
        .i_mode_we    (ctrl_we),
        .i_mode_wdata (i_io_wdata[nvac_pkg::MODE_LSB +: 2]),
        .i_addr       (st.addr[AW-1:0]),
        .i_data       (st.data),
        .o_busy       (busy),
        .o_mode       (mode),
        .o_arr_we     (arr_we),
        .o_arr_and    (arr_and),
        .o_arr_addr   (arr_addr),
        .o_arr_wdata  (arr_wdata)
    );

    nvac_mem #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .i_core_clk (i_core_clk),
        .i_addr     (mem_addr),
        .i_we       (arr_we),
        .i_and_mode (arr_and),
        .i_wdata    (arr_wdata),
        .o_rdata    (mem_rdata)
    );

    assign o_io_rdata = st.rdata;
    assign o_cpu_stall = st.stall;
    assign o_ready_irq = st.irq;

    property p_read_stall;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        rd_trig |=> o_cpu_stall [*4] ##1 !o_cpu_stall;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

    property p_write_stall;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        wr_start |=> o_cpu_stall [*2] ##1 !o_cpu_stall;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall not two cycles");

    property p_mwe_timeout;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (ctrl_we && i_io_wdata[nvac_pkg::MWE_BIT] && !wr_start) ##1 !ctrl_we [*4] |=> !st.mwe;
    endproperty
    a_mwe_timeout: assert property (p_mwe_timeout) else $error("master enable did not time out");

    property p_no_start_without_mwe;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (ctrl_we && i_io_wdata[nvac_pkg::WSTROBE_BIT] && !st.mwe && !busy) |=> !busy;
    endproperty
    a_no_start_without_mwe: assert property (p_no_start_without_mwe) else $error("write began without enable");

    property p_start_sets_busy;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (wr_start && i_io_wdata[nvac_pkg::MODE_LSB +: 2] != nvac_pkg::MODE_RESERVED) |=> busy;
    endproperty
    a_start_sets_busy: assert property (p_start_sets_busy) else $error("accepted write did not start");

    property p_mode_frozen;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (busy && ctrl_we) |=> $stable(mode);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed while busy");

    property p_addr_frozen;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        busy |=> $stable(st.addr);
    endproperty
    a_addr_frozen: assert property (p_addr_frozen) else $error("address changed while busy");

    property p_hi_reads_zero;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_io_re && i_io_addr == nvac_pkg::ADDR_HI_ADDR) |=> o_io_rdata[7:4] == 4'h0;
    endproperty
    a_hi_reads_zero: assert property (p_hi_reads_zero) else $error("upper address bits not zero");

    property p_irq_level;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (next_st.rie && i_global_irq_en && !busy) |=> o_ready_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("ready interrupt missing");

    property p_irq_gated;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!next_st.rie || !i_global_irq_en || busy) |=> !o_ready_irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("ready interrupt while disabled");

    property p_read_loads_data;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (rd_trig && !arr_we) ##2 !(i_io_we && i_io_addr == nvac_pkg::DATA_ADDR) |=> st.data == $past(mem_rdata);
    endproperty
    a_read_loads_data: assert property (p_read_loads_data) else $error("read byte not loaded");
endmodule

// [dv/nvac_cpu_model.sv]
// cpu core model driving the io port of the access controller
// assumes the port samples on rising i_core_clk; drives at falling edge
`timescale 1ns/100ps
module nvac_cpu_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_cpu_stall,
    input  wire logic [7:0] i_io_rdata,
    output logic      [5:0] o_io_addr,
    output logic            o_io_we,
    output logic            o_io_re,
    output logic      [7:0] o_io_wdata
);
    initial
    begin
        o_io_addr  = 6'h00;
        o_io_we    = 1'b0;
        o_io_re    = 1'b0;
        o_io_wdata = 8'h00;
    end
    // released bus shows inverted leftovers
    task automatic release_bus();
        o_io_we    = 1'b0;
        o_io_re    = 1'b0;
        o_io_addr  = ~o_io_addr;
        o_io_wdata = ~o_io_wdata;
    endtask
    // a halted core issues nothing
    task automatic wait_run();
        @(negedge i_core_clk);
        while (i_cpu_stall !== 1'b0)
        begin
            release_bus();
            @(negedge i_core_clk);
        end
    endtask
    task automatic io_write(input logic [5:0] addr, input logic [7:0] data);
        wait_run();
        o_io_addr  = addr;
        o_io_wdata = data;
        o_io_re    = 1'b0;
        o_io_we    = 1'b1;
        @(posedge i_core_clk);
    endtask
    task automatic io_read(input logic [5:0] addr, output logic [7:0] data);
        wait_run();
        o_io_addr = addr;
        o_io_we   = 1'b0;
        o_io_re   = 1'b1;
        @(posedge i_core_clk);
        @(negedge i_core_clk);
        release_bus();
        data = i_io_rdata;
    endtask
    task automatic io_idle(input int n, output int stalls);
        stalls = 0;
        repeat (n)
        begin
            @(negedge i_core_clk);
            release_bus();
            if (i_cpu_stall === 1'b1)
                stalls++;
            @(posedge i_core_clk);
        end
    endtask
endmodule

// [dv/tb.sv]
// self-checking bench of the nonvolatile byte access controller
// assumes the cpu model on the io port and shortened programming counts
`timescale 1ns/100ps
module tb;
    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic       por_n    = 1'b0;
    logic       rc_osc   = 1'b0;
    logic       gie      = 1'b0;
    logic       rie      = 1'b0;
    logic [5:0] io_addr;
    logic       io_we;
    logic       io_re;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       stall;
    logic       irq;
    logic [7:0] mem [1024];
    logic [7:0] rd;
    logic [7:0] d;
    logic [9:0] a;
    int         st;
    int         failures = 0;
    int         checks   = 0;
    int         seed     = 27405;
    always #20 clk = ~clk;
    always #65 rc_osc = ~rc_osc;
    nvac_top #(.DEPTH(1024), .AW(10), .ATOMIC_CYC(12), .SPLIT_CYC(8)) i_nvac_top (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_rc_osc(rc_osc),
        .i_io_addr(io_addr), .i_io_we(io_we), .i_io_re(io_re), .i_io_wdata(io_wdata),
        .i_global_irq_en(gie), .o_io_rdata(io_rdata), .o_cpu_stall(stall), .o_ready_irq(irq));
    nvac_cpu_model i_nvac_cpu_model (
        .i_core_clk(clk), .i_cpu_stall(stall), .i_io_rdata(io_rdata), .o_io_addr(io_addr),
        .o_io_we(io_we), .o_io_re(io_re), .o_io_wdata(io_wdata));
    function automatic logic [7:0] ctrl_val(input logic [1:0] m, input logic mwe, ws, rs);
        ctrl_val = {2'b00, m, rie, mwe, ws, rs};
    endfunction
    function automatic logic [7:0] prog_result(input logic [1:0] m, input logic [7:0] old, dat);
        case (m)
            2'b00:   prog_result = dat;
            2'b01:   prog_result = 8'hFF;
            2'b10:   prog_result = old & dat;
            default: prog_result = old;
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] v);
        i_nvac_cpu_model.io_write(ad, v);
    endtask
    task automatic rdr(input logic [5:0] ad, output logic [7:0] v);
        i_nvac_cpu_model.io_read(ad, v);
    endtask
    task automatic idle(input int n);
        i_nvac_cpu_model.io_idle(n, st);
    endtask
    task automatic set_addr(input logic [9:0] ad);
        wr(nvac_pkg::ADDR_HI_ADDR, {6'h00, ad[9:8]});
        wr(nvac_pkg::ADDR_LO_ADDR, ad[7:0]);
    endtask
    task automatic start(input logic [9:0] ad, input logic [7:0] v, input logic [1:0] m);
        set_addr(ad);
        wr(nvac_pkg::DATA_ADDR, v);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(m, 1'b1, 1'b0, 1'b0));
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(m, 1'b0, 1'b1, 1'b0));
        mem[ad] = prog_result(m, mem[ad], v);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            rdr(nvac_pkg::CTRL_ADDR, rd);
            n++;
        end
        while (rd[1] !== 1'b0 && n < 100);
        check({7'h00, rd[1]}, 8'h00);
    endtask
    task automatic prog(input logic [9:0] ad, input logic [7:0] v, input logic [1:0] m);
        start(ad, v, m);
        idle(4);
        check(8'(st), 8'h02);
        wait_idle();
    endtask
    task automatic fetch_check(input logic [9:0] ad);
        set_addr(ad);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b0, 1'b1));
        idle(6);
        check(8'(st), 8'h04);
        rdr(nvac_pkg::DATA_ADDR, rd);
        check(rd, mem[ad]);
    endtask
    task automatic pulse_reset();
        idle(1);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
    endtask
    initial
    begin
        #(40 * 20000);
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        por_n = 1'b1;
        rst_n = 1'b1;
        gie   = 1'b1;
        rdr(6'h10, rd);
        check(rd, 8'h00);
        wr(nvac_pkg::ADDR_HI_ADDR, 8'hFF);
        rdr(nvac_pkg::ADDR_HI_ADDR, rd);
        check(rd, 8'h0F);
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check(rd, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed));
            prog(a, 8'($random(seed)), 2'b00);
            fetch_check(a);
        end
        for (int m = 1; m < 4; m++)
        begin
            start(a, 8'($random(seed)), 2'(m));
            idle(3);
            wait_idle();
            fetch_check(a);
        end
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b1, 1'b0));
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check({7'h00, rd[1]}, 8'h00);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b1, 1'b1, 1'b0));
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check({7'h00, rd[1]}, 8'h00);
        idle(6);
        for (int gap = 4; gap < 6; gap++)
        begin
            d = 8'($random(seed));
            wr(nvac_pkg::DATA_ADDR, d);
            wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b1, 1'b0, 1'b0));
            idle(gap - 1);
            wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b1, 1'b0));
            rdr(nvac_pkg::CTRL_ADDR, rd);
            check({7'h00, rd[1]}, {7'h00, gap == 4});
            if (gap == 4)
                mem[a] = d;
            wait_idle();
            fetch_check(a);
        end
        rie = 1'b1;
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b0, 1'b0));
        idle(3);
        check({7'h00, irq}, 8'h01);
        @(negedge clk) gie = 1'b0;
        idle(3);
        check({7'h00, irq}, 8'h00);
        @(negedge clk) gie = 1'b1;
        a = a ^ 10'h155;
        d = 8'($random(seed));
        start(a, d, 2'b00);
        idle(4);
        check({7'h00, irq}, 8'h00);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b11, 1'b0, 1'b0, 1'b0));
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check(rd, 8'h0A);
        wr(nvac_pkg::ADDR_LO_ADDR, ~a[7:0]);
        rdr(nvac_pkg::ADDR_LO_ADDR, rd);
        check(rd, a[7:0]);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b0, 1'b1));
        rdr(nvac_pkg::DATA_ADDR, rd);
        check(rd, d);
        wait_idle();
        idle(2);
        check({7'h00, irq}, 8'h01);
        rie = 1'b0;
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b00, 1'b0, 1'b0, 1'b0));
        idle(2);
        check({7'h00, irq}, 8'h00);
        fetch_check(a);
        start(a, 8'h5A, 2'b01);
        idle(3);
        pulse_reset();
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check(rd, 8'h12);
        wait_idle();
        fetch_check(a);
        wr(nvac_pkg::CTRL_ADDR, ctrl_val(2'b10, 1'b0, 1'b0, 1'b0));
        pulse_reset();
        rdr(nvac_pkg::CTRL_ADDR, rd);
        check(rd, 8'h00);
        stop_test();
    end
endmodule
